/* swdt_top.sv */
/*
  Supervisor watchdog timer: kick edge detection, window and fault pulse timing.
  Assumes synchronous inputs; the fault pin is open-drain with an external pull-up.
*/
`timescale 1ns/100ps
`default_nettype none
module swdt_top (
    // Clock and reset
    input  wire logic                        clock,
    input  wire logic                        rst,
    // Host side
    input  wire logic                        watchdog_kick_in,
    // Timebase, one tick period in clocks set by the capacitor
    input  wire logic [swdt_pkg::TB_W-1:0]   timebase_cap_pin,
    input  wire logic                        internal_supply_rail,
    // Supervisor events
    input  wire logic                        supply_low_lockout,
    // Open-drain fault pin
    output logic                             watchdog_fault_out_n,
    output logic                             watchdog_fault_oe
);
    localparam logic [swdt_pkg::CNT_W-1:0] NORMAL_TICKS = swdt_pkg::CNT_W'(swdt_pkg::NORMAL_WINDOW_TICKS);
    localparam logic [swdt_pkg::CNT_W-1:0] EXT_TICKS = swdt_pkg::CNT_W'(swdt_pkg::EXTENDED_WINDOW_TICKS);
    localparam logic [swdt_pkg::CNT_W-1:0] PULSE_TICKS = swdt_pkg::CNT_W'(swdt_pkg::FAULT_PULSE_TICKS);
    localparam logic [swdt_pkg::CNT_W-1:0] NORMAL_LAST = NORMAL_TICKS - 1'b1;
    localparam logic [swdt_pkg::CNT_W-1:0] EXT_LAST    = EXT_TICKS - 1'b1;
    localparam logic [swdt_pkg::CNT_W-1:0] PULSE_LAST  = PULSE_TICKS - 1'b1;

    swdt_pkg::swdt_state_e     state;
    swdt_pkg::swdt_state_e     next_state;
    logic [swdt_pkg::CNT_W-1:0] ticks;
    logic [swdt_pkg::CNT_W-1:0] next_ticks;
    logic                      kick_prev;
    logic                      lockout_prev;
    logic                      tick;
    logic                      enabled;
    logic                      kick_edge;
    logic                      lockout_rise;
    logic                      next_fault_oe;

    // Strap disables the whole timer, tick generator included
    assign enabled = !internal_supply_rail;
    assign kick_edge = watchdog_kick_in ^ kick_prev;
    assign lockout_rise = supply_low_lockout & ~lockout_prev;

    swdt_tick_gen u_tick (
        .clock       (clock),
        .rst         (rst),
        .enable      (enabled),
        .tick_period (timebase_cap_pin),
        .tick        (tick)
    );

    always_comb begin
        next_state = state;
        next_ticks = ticks;
        if (!enabled) begin
            next_state = swdt_pkg::SWDT_NORMAL;
            next_ticks = '0;
        end else if (lockout_rise) begin
            next_state = swdt_pkg::SWDT_PULSE;
            next_ticks = '0;
        end else begin
            case (state)
                swdt_pkg::SWDT_NORMAL,
                swdt_pkg::SWDT_EXTENDED: begin
                    if (kick_edge) begin
                        next_state = swdt_pkg::SWDT_NORMAL;
                        next_ticks = '0;
                    end else if (tick) begin
                        // Tick counting keeps the ratios exact at any capacitor
                        if (ticks + 1'b1 >= ((state == swdt_pkg::SWDT_NORMAL) ? NORMAL_TICKS : EXT_TICKS)) begin
                            next_state = swdt_pkg::SWDT_PULSE;
                            next_ticks = '0;
                        end else begin
                            next_ticks = ticks + 1'b1;
                        end
                    end
                end
                swdt_pkg::SWDT_PULSE: begin
                    // Kicks during the pulse are ignored
                    if (tick) begin
                        if (ticks + 1'b1 >= PULSE_TICKS) begin
                            next_state = swdt_pkg::SWDT_EXTENDED;
                            next_ticks = '0;
                        end else begin
                            next_ticks = ticks + 1'b1;
                        end
                    end
                end
                default: begin
                    next_state = swdt_pkg::SWDT_NORMAL;
                    next_ticks = '0;
                end
            endcase
        end
        // Pin changes on the same edge as the state, from a flip-flop fed by next_state
        next_fault_oe = (next_state == swdt_pkg::SWDT_PULSE);
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            state <= swdt_pkg::SWDT_NORMAL;
            ticks <= '0;
            kick_prev <= 1'b0;
            lockout_prev <= 1'b0;
            watchdog_fault_oe <= 1'b0;
        end else begin
            state <= next_state;
            ticks <= next_ticks;
            kick_prev <= watchdog_kick_in;
            lockout_prev <= supply_low_lockout;
            watchdog_fault_oe <= next_fault_oe;
        end
    end

    // Data level is always low; only the enable moves
    assign watchdog_fault_out_n = 1'b0;

    // Checker-side timing model, kept apart from the state machine so that
    // a slip in window or pulse counting shows up as a disagreement
    logic [swdt_pkg::CNT_W-1:0] win_ticks;
    logic [swdt_pkg::CNT_W-1:0] next_win_ticks;
    logic [swdt_pkg::CNT_W-1:0] pulse_ticks;
    logic [swdt_pkg::CNT_W-1:0] next_pulse_ticks;
    logic [swdt_pkg::CNT_W-1:0] win_last;
    logic                      win_long;
    logic                      next_win_long;
    logic                      window_due;
    logic                      pulse_due;

    // Every pulse is followed by the long window, lockout pulses included
    assign win_last = win_long ? EXT_LAST : NORMAL_LAST;
    assign window_due = tick && !kick_edge && (win_ticks == win_last);
    assign pulse_due = tick && (pulse_ticks == PULSE_LAST);

    always_comb begin
        next_win_ticks = win_ticks;
        next_win_long = win_long;
        next_pulse_ticks = pulse_ticks;
        if (!enabled) begin
            next_win_ticks = '0;
            next_win_long = 1'b0;
            next_pulse_ticks = '0;
        end else begin
            if (watchdog_fault_oe || lockout_rise) begin
                next_win_ticks = '0;
                next_win_long = 1'b1;
            end else if (kick_edge) begin
                next_win_ticks = '0;
                next_win_long = 1'b0;
            end else if (tick) begin
                next_win_ticks = win_ticks + 1'b1;
            end
            if (!watchdog_fault_oe || lockout_rise) begin
                next_pulse_ticks = '0;
            end else if (tick) begin
                next_pulse_ticks = pulse_ticks + 1'b1;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            win_ticks <= '0;
            win_long <= 1'b0;
            pulse_ticks <= '0;
        end else begin
            win_ticks <= next_win_ticks;
            win_long <= next_win_long;
            pulse_ticks <= next_pulse_ticks;
        end
    end

    chk_strap_quiet: assert property (@(posedge clock) disable iff (rst)
        internal_supply_rail |=> !watchdog_fault_oe) else $error("fault driven while disabled");
    chk_never_high: assert property (@(posedge clock) disable iff (rst)
        !watchdog_fault_out_n) else $error("fault pin driven high");
    chk_lockout_pulse: assert property (@(posedge clock) disable iff (rst)
        (lockout_rise && enabled) |=> watchdog_fault_oe) else $error("lockout gave no pulse");
    // A strap in the last pulse cycle also drops the pin, so that cycle must be enabled
    sequence s_pulse_end;
        (watchdog_fault_oe && enabled) ##1 !watchdog_fault_oe;
    endsequence
    chk_after_pulse: assert property (@(posedge clock) disable iff (rst)
        s_pulse_end |-> state == swdt_pkg::SWDT_EXTENDED) else $error("no extended window after pulse");
    chk_kick_restart: assert property (@(posedge clock) disable iff (rst)
        (enabled && !lockout_rise && kick_edge && state != swdt_pkg::SWDT_PULSE) |=> ticks == '0)
        else $error("kick did not restart window");
    chk_pulse_tie: assert property (@(posedge clock) disable iff (rst)
        watchdog_fault_oe == (state == swdt_pkg::SWDT_PULSE)) else $error("pin and state disagree");
    chk_tick_only: assert property (@(posedge clock) disable iff (rst)
        (!tick && !kick_edge && !lockout_rise && enabled) |=> $stable(ticks) || ticks == '0)
        else $error("count moved without tick");
    chk_count_bound: assert property (@(posedge clock) disable iff (rst)
        ticks < EXT_TICKS) else $error("count past extended window");

    // Window steps: quiet cycles keep the pin released, the last tick trips it
    sequence s_window_quiet;
        enabled && !lockout_rise && !watchdog_fault_oe && !window_due;
    endsequence
    sequence s_window_due;
        enabled && !lockout_rise && !watchdog_fault_oe && window_due;
    endsequence
    // Pulse steps: held until its last tick, then released
    sequence s_pulse_hold;
        enabled && !lockout_rise && watchdog_fault_oe && !pulse_due;
    endsequence
    sequence s_pulse_due;
        enabled && !lockout_rise && watchdog_fault_oe && pulse_due;
    endsequence
    chk_window_hold: assert property (@(posedge clock) disable iff (rst)
        s_window_quiet |=> !watchdog_fault_oe) else $error("fault before the window ran out");
    chk_window_trip: assert property (@(posedge clock) disable iff (rst)
        s_window_due |=> watchdog_fault_oe) else $error("window ran out with no fault");
    chk_pulse_length: assert property (@(posedge clock) disable iff (rst)
        s_pulse_hold |=> watchdog_fault_oe) else $error("fault pulse cut short");
    chk_pulse_release: assert property (@(posedge clock) disable iff (rst)
        s_pulse_due |=> !watchdog_fault_oe) else $error("fault pulse held too long");
endmodule
`default_nettype wire

/* swdt_pkg.sv */
/*
  Shared constants for the supervisor watchdog timer.
  Assumes a 250 MHz clock and a timebase tick derived from the capacitor pin.
*/
`default_nettype none
package swdt_pkg;
    // Nominal periods at the nominal timing capacitor
    localparam int unsigned NORMAL_WINDOW_US = 1620000;
    localparam int unsigned EXTENDED_WINDOW_US = 12900000;
    localparam int unsigned FAULT_PULSE_US = 202000;
    localparam int unsigned NOMINAL_CAP_PF = 10000;
    // One tick per microsecond at the nominal capacitor
    localparam int unsigned TICK_US = 1;
    localparam int unsigned CLOCK_MHZ = 250;
    localparam int unsigned NOMINAL_TICK_CYCLES = TICK_US * CLOCK_MHZ;
    localparam int unsigned NORMAL_WINDOW_TICKS = NORMAL_WINDOW_US / TICK_US;
    localparam int unsigned EXTENDED_WINDOW_TICKS = EXTENDED_WINDOW_US / TICK_US;
    localparam int unsigned FAULT_PULSE_TICKS = FAULT_PULSE_US / TICK_US;
    localparam int CNT_W = 24;
    localparam int TB_W = 20;
    typedef enum logic [1:0] {
        SWDT_NORMAL,
        SWDT_PULSE,
        SWDT_EXTENDED
    } swdt_state_e;
endpackage
`default_nettype wire

/* swdt_tick_gen.sv */
/*
  Timebase tick generator: one-cycle tick every tick_period clocks.
  Assumes tick_period is nonzero and steady while enabled.
*/
`timescale 1ns/100ps
`default_nettype none
module swdt_tick_gen (
    // Clock and reset
    input  wire logic                        clock,
    input  wire logic                        rst,
    // Control
    input  wire logic                        enable,
    input  wire logic [swdt_pkg::TB_W-1:0]   tick_period,
    // Tick out
    output logic                             tick
);
    logic [swdt_pkg::TB_W-1:0] count;
    logic [swdt_pkg::TB_W-1:0] next_count;
    logic                      next_tick;

    always_comb begin
        next_count = count;
        next_tick = 1'b0;
        if (!enable) begin
            next_count = '0;
        end else if (count + 1'b1 >= tick_period) begin
            next_count = '0;
            next_tick = 1'b1;
        end else begin
            next_count = count + 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            count <= '0;
            tick <= 1'b0;
        end else begin
            count <= next_count;
            tick <= next_tick;
        end
    end
endmodule
`default_nettype wire

/* swdt_host_model.sv */
/*
  Host model: toggles the kick input at a fixed spacing while enabled.
  Assumes the bench enables it only after reset is released.
*/
`timescale 1ns/100ps
`default_nettype none
module swdt_host_model #(
    parameter int SPACING = 100
) (
    // Clock and control
    input  wire logic clock,
    input  wire logic enable,
    // Kick line
    output var logic  kick
);
    int cnt = 0;
    initial kick = 1'b0;
    // Spacing far inside the window, so a healthy host never trips it
    always @(posedge clock) begin
        if (enable && cnt == SPACING - 1) begin
            kick <= ~kick;
            cnt  <= 0;
        end else if (enable) begin
            cnt <= cnt + 1;
        end
    end
endmodule
`default_nettype wire

/* supervisor_watchdog_timer_tb.sv */
/*
  Self-checking bench for the watchdog: healthy kicks, lockout pulse, strap.
  Assumes one tick per clock outside the scaling scenario; full windows and pulses
  exceed the run, so their ends are left to the design's assertions.
*/
`timescale 1ns/100ps
`default_nettype none
module supervisor_watchdog_timer_tb;
    localparam int             SPACING = 100;
    logic                      clock   = 1'b0;
    logic                      rst     = 1'b1;
    logic                      host_en = 1'b0;
    logic                      strap   = 1'b0;
    logic                      lockout = 1'b0;
    logic [swdt_pkg::TB_W-1:0] period  = 20'h00001;
    logic                      kick;
    logic                      out_n;
    logic                      oe;
    int                        n_fail      = 0;
    int                        checks_done = 0;

    always #2 clock = ~clock;

    swdt_host_model #(.SPACING(SPACING)) host_u (.clock(clock), .enable(host_en), .kick(kick));
    swdt_top dut_u (.clock(clock), .rst(rst), .watchdog_kick_in(kick), .timebase_cap_pin(period),
        .internal_supply_rail(strap), .supply_low_lockout(lockout),
        .watchdog_fault_out_n(out_n), .watchdog_fault_oe(oe));

    task automatic check1(input string what, input logic exp, input logic got);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic check_num(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %0d seen %0d", what, exp, got);
        end
    endtask

    task automatic wait_oe(input logic lvl, input int bound);
        for (int i = 0; i < bound && oe !== lvl; i++) @(negedge clock);
    endtask

    task automatic test_done;
        $display("checks_done %0d n_fail %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    task automatic t_reset;
        check1("fault_oe", 1'b0, oe);
        check1("fault_out_n", 1'b0, out_n);
    endtask

    // Steady kicks must restart the count every time
    task automatic t_kicked;
        int          highs;
        logic [31:0] peak;
        highs = 0;
        peak = 32'h00000000;
        @(posedge clock) host_en <= 1'b1;
        for (int i = 0; i < 20000; i++) begin
            @(negedge clock);
            if (oe !== 1'b0) highs++;
            // Before the first kick the count still runs from reset
            if (i >= 2 * SPACING && dut_u.ticks >= peak) peak = 32'(dut_u.ticks);
        end
        check1("no fault while kicked", 1'b1, highs == 0);
        check_num("peak ticks between kicks", 32'(SPACING - 1), peak);
    endtask

    // Four clocks per tick: 400 clocks must give exactly 100 ticks
    task automatic t_scale;
        logic [31:0] start;
        @(posedge clock) host_en <= 1'b0;
        period <= 20'h00004;
        repeat (8) @(negedge clock);
        start = 32'(dut_u.ticks);
        repeat (400) @(negedge clock);
        check_num("ticks per 400 clocks", 32'h00000064, 32'(dut_u.ticks) - start);
        check1("no fault while scaled", 1'b0, oe);
        @(posedge clock) period <= 20'h00001;
        host_en <= 1'b1;
    endtask

    task automatic t_lockout;
        int drops;
        drops = 0;
        @(posedge clock) lockout <= 1'b1;
        wait_oe(1'b1, 3);
        check1("fault_oe after lockout", 1'b1, oe);
        // Kicks keep running: they must not cut the pulse short
        repeat (5000) begin
            @(negedge clock);
            if (oe !== 1'b1 || out_n !== 1'b0) drops++;
        end
        check1("pulse holds with kicks", 1'b1, drops == 0);
        @(posedge clock) lockout <= 1'b0;
    endtask

    task automatic t_strap;
        int highs;
        highs = 0;
        @(posedge clock) strap <= 1'b1;
        wait_oe(1'b0, 4);
        check1("fault_oe when strapped", 1'b0, oe);
        @(posedge clock) lockout <= 1'b1;
        repeat (20) begin
            @(negedge clock);
            if (oe !== 1'b0) highs++;
        end
        check1("lockout ignored when strapped", 1'b1, highs == 0);
        @(posedge clock) lockout <= 1'b0;
        strap <= 1'b0;
    endtask

    // Reset in the middle of a pulse must release the pin at once
    task automatic t_midreset;
        @(posedge clock) lockout <= 1'b1;
        wait_oe(1'b1, 3);
        check1("fault_oe before reset", 1'b1, oe);
        @(posedge clock) rst <= 1'b1;
        lockout <= 1'b0;
        repeat (2) @(negedge clock);
        check1("fault_oe in reset", 1'b0, oe);
        @(posedge clock) rst <= 1'b0;
        repeat (2) @(negedge clock);
        check1("fault_oe after reset", 1'b0, oe);
        check1("fault_out_n after reset", 1'b0, out_n);
    endtask

    initial begin
        repeat (12) @(posedge clock);
        rst <= 1'b0;
        @(negedge clock);
        t_reset();
        t_kicked();
        t_scale();
        t_lockout();
        t_strap();
        t_midreset();
        test_done();
    end

    // Tests need about 25600 cycles
    initial begin
        repeat (60000) @(posedge clock);
        n_fail++;
        test_done();
    end
endmodule
`default_nettype wire
